// File: include/telemetry_status_pkg.sv
// Purpose: constants and carriers for the telemetry and status readback bank
// Assumes: 20 MHz clk, command-level access behind the two-wire engine
// Notes: command codes are the byte codes seen on the two-wire bus
package telemetry_status_pkg;

    // ------------------------------------------------------------
    // command codes
    // ------------------------------------------------------------
    localparam logic [7:0] CMD_GLOBAL_FAULT_CLEAR = 8'h03;
    localparam logic [7:0] CMD_VENDOR_FAULT_STATUS = 8'h80;
    localparam logic [7:0] CMD_INPUT_VOLTAGE = 8'h88;
    localparam logic [7:0] CMD_INPUT_CURRENT = 8'h89;
    localparam logic [7:0] CMD_OUTPUT_VOLTAGE = 8'h8B;
    localparam logic [7:0] CMD_OUTPUT_CURRENT = 8'h8C;
    localparam logic [7:0] CMD_DIE_TEMPERATURE = 8'h8D;
    localparam logic [7:0] CMD_INPUT_POWER = 8'h97;

    // ------------------------------------------------------------
    // status field positions and reset values
    // ------------------------------------------------------------
    localparam int UV_BIT = 0;
    localparam int OT_BIT = 1;
    localparam int EVENT_BIT = 2;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [7:0] READING_RESET = 8'h00;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_HZ = 20_000_000;
    localparam int FAST_REFRESH_NS = 95_000;
    localparam int SLOW_REFRESH_NS = 190_000;
    localparam int FAST_REFRESH_CYC =
        FAST_REFRESH_NS / (1_000_000_000 / CLK_HZ);
    localparam int SLOW_REFRESH_CYC =
        SLOW_REFRESH_NS / (1_000_000_000 / CLK_HZ);

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] code;
        logic rd;
        logic wr;
        logic has_data;
        logic [7:0] wdata;
    } cmd_req_t;

    typedef struct packed {
        logic ack;
        logic nack;
        logic [7:0] rdata;
    } cmd_rsp_t;

    typedef struct packed {
        logic [7:0] input_voltage;
        logic [7:0] input_current;
        logic [7:0] output_current;
        logic [7:0] die_temperature;
        logic [7:0] input_power;
    } samples_t;

endpackage

// File: design/telemetry_status_readback.sv
// Purpose: status byte and telemetry readback behind the command port
// Assumes: flag inputs are asynchronous analog levels; samples are on clk
// Notes: currents and input power are captured on the fast refresh tick, the other samples on the slow refresh tick
`timescale 1ns/1ps

module telemetry_status_readback
    import telemetry_status_pkg::*;
#(
    parameter int VOUT_W = 10
) (
    input logic clk,
    input logic rst_b,
    input cmd_req_t cmd_req,
    output cmd_rsp_t cmd_rsp,
    input samples_t samples,
    input logic [VOUT_W-1:0] output_sense_5mv,
    input logic vout_step_coarse,
    input logic stage_conduction_event_flag,
    input logic stage_overtemp_live_flag,
    input logic driver_supply_undervoltage_flag,
    output logic [7:0] vendor_fault_status
);

    initial begin
        if (VOUT_W < 9 || VOUT_W > 16) begin
            $error("VOUT_W must be 9 to 16");
        end
    end

    // ------------------------------------------------------------
    // flag synchronisers
    // ------------------------------------------------------------
    logic [2:0] flag_meta_q;
    logic [2:0] flag_sync_q;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            flag_meta_q <= 3'h0;
            flag_sync_q <= 3'h0;
        end else begin
            flag_meta_q <= {stage_conduction_event_flag,
                            stage_overtemp_live_flag,
                            driver_supply_undervoltage_flag};
            flag_sync_q <= flag_meta_q;
        end
    end

    logic evt_now;
    logic ot_now;
    logic uv_now;
    assign evt_now = flag_sync_q[2];
    assign ot_now = flag_sync_q[1];
    assign uv_now = flag_sync_q[0];

    // ------------------------------------------------------------
    // status byte
    // ------------------------------------------------------------
    logic evt_q;
    logic uv_q;
    logic status_wr;
    logic global_clear;

    assign status_wr = cmd_req.wr && cmd_req.has_data &&
        cmd_req.code == CMD_VENDOR_FAULT_STATUS;
    assign global_clear = cmd_req.wr && !cmd_req.has_data &&
        cmd_req.code == CMD_GLOBAL_FAULT_CLEAR;

    function automatic logic sticky_next(logic cur, logic cond,
                                         logic clr);
        // set wins over clear; live cause re-sets at once
        sticky_next = cond | (cur & ~clr);
    endfunction

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            evt_q <= STATUS_RESET[EVENT_BIT];
            uv_q <= STATUS_RESET[UV_BIT];
        end else begin
            evt_q <= sticky_next(evt_q, evt_now, global_clear ||
                (status_wr && cmd_req.wdata[EVENT_BIT]));
            uv_q <= sticky_next(uv_q, uv_now, global_clear ||
                (status_wr && cmd_req.wdata[UV_BIT]));
        end
    end

    always_comb begin
        vendor_fault_status = STATUS_RESET;
        vendor_fault_status[EVENT_BIT] = evt_q;
        vendor_fault_status[OT_BIT] = ot_now;
        vendor_fault_status[UV_BIT] = uv_q;
    end

    // ------------------------------------------------------------
    // refresh dividers
    // ------------------------------------------------------------
    logic [11:0] fast_cnt_q;
    logic [11:0] slow_cnt_q;
    logic fast_tick;
    logic slow_tick;

    assign fast_tick = fast_cnt_q == 12'(FAST_REFRESH_CYC - 1);
    assign slow_tick = slow_cnt_q == 12'(SLOW_REFRESH_CYC - 1);

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            fast_cnt_q <= 12'h000;
            slow_cnt_q <= 12'h000;
        end else begin
            fast_cnt_q <= fast_tick ? 12'h000 : fast_cnt_q + 12'h001;
            slow_cnt_q <= slow_tick ? 12'h000 : slow_cnt_q + 12'h001;
        end
    end

    // ------------------------------------------------------------
    // output voltage scaling
    // ------------------------------------------------------------
    function automatic logic [7:0] sat8(logic [VOUT_W-1:0] v);
        sat8 = (v > VOUT_W'(8'hFF)) ? 8'hFF : v[7:0];
    endfunction

    logic [7:0] vout_scaled;
    assign vout_scaled = vout_step_coarse ?
        sat8(output_sense_5mv >> 1) : sat8(output_sense_5mv);

    // ------------------------------------------------------------
    // telemetry capture
    // ------------------------------------------------------------
    logic [7:0] input_voltage_reading_q;
    logic [7:0] input_current_reading_q;
    logic [7:0] output_voltage_reading_q;
    logic [7:0] output_current_reading_q;
    logic [7:0] die_temperature_reading_q;
    logic [7:0] input_power_reading_q;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            input_current_reading_q <= READING_RESET;
            output_current_reading_q <= READING_RESET;
            input_power_reading_q <= READING_RESET;
        end else if (fast_tick) begin
            input_current_reading_q <= samples.input_current;
            output_current_reading_q <= samples.output_current;
            input_power_reading_q <= samples.input_power;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            input_voltage_reading_q <= READING_RESET;
            output_voltage_reading_q <= READING_RESET;
            die_temperature_reading_q <= READING_RESET;
        end else if (slow_tick) begin
            input_voltage_reading_q <= samples.input_voltage;
            output_voltage_reading_q <= vout_scaled;
            die_temperature_reading_q <= samples.die_temperature;
        end
    end

    // ------------------------------------------------------------
    // command answers
    // ------------------------------------------------------------
    logic [8:0] rd_mux;

    always_comb begin
        unique case (cmd_req.code)
            CMD_VENDOR_FAULT_STATUS: rd_mux = {1'b1, vendor_fault_status};
            CMD_INPUT_VOLTAGE: rd_mux = {1'b1, input_voltage_reading_q};
            CMD_INPUT_CURRENT: rd_mux = {1'b1, input_current_reading_q};
            CMD_OUTPUT_VOLTAGE: rd_mux = {1'b1, output_voltage_reading_q};
            CMD_OUTPUT_CURRENT: rd_mux = {1'b1, output_current_reading_q};
            CMD_DIE_TEMPERATURE: rd_mux = {1'b1, die_temperature_reading_q};
            CMD_INPUT_POWER: rd_mux = {1'b1, input_power_reading_q};
            default: rd_mux = 9'h000;
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cmd_rsp <= '0;
        end else begin
            cmd_rsp.ack <= (cmd_req.rd && rd_mux[8]) ||
                status_wr || global_clear;
            cmd_rsp.nack <= (cmd_req.rd && !rd_mux[8]) ||
                (cmd_req.wr && !status_wr && !global_clear);
            if (cmd_req.rd && rd_mux[8]) begin
                cmd_rsp.rdata <= rd_mux[7:0];
            end
        end
    end

endmodule // telemetry_status_readback

// File: dv/telemetry_status_readback_checker.sv
// Purpose: port checks for the readback bank
// Assumes: async flags pass two sync stages
// Notes: bound to every instance of the bank
`timescale 1ns/1ps
module telemetry_status_readback_checker
    import telemetry_status_pkg::*;
#(parameter int VOUT_W = 10) (
    input logic clk,
    input logic rst_b,
    input cmd_req_t cmd_req,
    input cmd_rsp_t cmd_rsp,
    input samples_t samples,
    input logic [VOUT_W-1:0] output_sense_5mv,
    input logic vout_step_coarse,
    input logic stage_conduction_event_flag,
    input logic stage_overtemp_live_flag,
    input logic driver_supply_undervoltage_flag,
    input logic [7:0] vendor_fault_status
);
    wire clr = cmd_req.wr && !cmd_req.has_data &&
        cmd_req.code == CMD_GLOBAL_FAULT_CLEAR;
    wire uv = driver_supply_undervoltage_flag;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    a_read_ack: assert property (cmd_req.rd && cmd_req.code == 8'h88 |=>
        cmd_rsp.ack) else $error("read not acked");
    a_ro_write: assert property (cmd_req.wr && cmd_req.code == 8'h89 |=>
        cmd_rsp.nack && !cmd_rsp.ack) else $error("reading write taken");
    a_ot_on: assert property (stage_overtemp_live_flag [*3] |->
        vendor_fault_status[OT_BIT]) else $error("overtemp not shown");
    a_ot_off: assert property (!stage_overtemp_live_flag [*3] |->
        !vendor_fault_status[OT_BIT]) else $error("overtemp stuck");
    a_uv_hold: assert property (vendor_fault_status[UV_BIT] && !cmd_req.wr
        |=> vendor_fault_status[UV_BIT]) else $error("uv flag lost");
    a_event_hold: assert property (vendor_fault_status[EVENT_BIT] &&
        !cmd_req.wr |=> vendor_fault_status[EVENT_BIT])
        else $error("event flag lost");
    a_uv_set: assert property (uv [*4] |-> vendor_fault_status[UV_BIT])
        else $error("uv flag not set");
    a_clear_ok: assert property (!uv [*4] ##0 clr |=>
        !vendor_fault_status[UV_BIT]) else $error("clear ignored");
    a_clear_refire: assert property (uv [*4] ##0 clr |=>
        vendor_fault_status[UV_BIT]) else $error("uv not set again");
    a_reset_zero: assert property ($rose(rst_b) |->
        vendor_fault_status == 8'h00) else $error("status not zero");
    c_clear: cover property (clr);
    c_nack: cover property (cmd_rsp.nack);
    c_all: cover property (vendor_fault_status == 8'h07);
endmodule // telemetry_status_readback_checker
bind telemetry_status_readback telemetry_status_readback_checker
    #(.VOUT_W(VOUT_W)) chk_i (.*);

// File: dv/host_model.sv
// Purpose: command host issuing single byte requests
// Assumes: requests driven at falling edge
// Notes: answer sampled at the falling edge half a cycle after the taking edge
`timescale 1ns/1ps
module host_model
    import telemetry_status_pkg::*;
(
    input logic clk,
    output cmd_req_t req,
    input cmd_rsp_t rsp
);
    initial req = '0;
    task automatic xfer(input logic [7:0] c, input logic r, input logic w,
                        input logic h, input logic [7:0] d,
                        output cmd_rsp_t o);
        @(negedge clk);
        req = '{code: c, rd: r, wr: w, has_data: h, wdata: d};
        @(negedge clk);
        o = rsp;
        req.rd = 1'b0;
        req.wr = 1'b0;
        req.wdata = ~d;
    endtask
endmodule // host_model

// File: dv/telemetry_status_readback_bench.sv
// Purpose: self-checking bench for the readback bank
// Assumes: refresh of all readings within 3800 cycles
// Notes: inputs change at falling edge only
`timescale 1ns/1ps
module telemetry_status_readback_bench
    import telemetry_status_pkg::*;
;
    logic clk = 0, rst_b = 0, coarse = 0, evt = 0, ot = 0, uv = 0;
    cmd_req_t req;
    cmd_rsp_t rsp, o;
    samples_t smp = '0;
    logic [9:0] sense = 10'h000;
    logic [7:0] st;
    int miscompares = 0, num_checks = 0;
    initial forever #25 clk = ~clk;
    host_model host (.clk(clk), .req(req), .rsp(rsp));
    telemetry_status_readback DUT (.clk(clk), .rst_b(rst_b), .cmd_req(req),
        .cmd_rsp(rsp), .samples(smp), .output_sense_5mv(sense),
        .vout_step_coarse(coarse), .stage_conduction_event_flag(evt),
        .stage_overtemp_live_flag(ot),
        .driver_supply_undervoltage_flag(uv), .vendor_fault_status(st));
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task automatic rd(input logic [7:0] c, input logic [7:0] e);
        host.xfer(c, 1'b1, 1'b0, 1'b0, 8'h00, o);
        chk({7'h00, o.ack}, 8'h01);
        chk(o.rdata, e);
    endtask
    task automatic wr(input logic [7:0] c, input logic h, input logic [7:0] d,
                      input logic a);
        host.xfer(c, 1'b0, 1'b1, h, d, o);
        chk({6'h00, o.ack, o.nack}, {6'h00, a, ~a});
    endtask
    task automatic t_reset;
        rd(CMD_VENDOR_FAULT_STATUS, 8'h00);
        rd(CMD_INPUT_POWER, 8'h00);
        $display("t_reset done");
    endtask
    task automatic t_read;
        smp = '{8'h11, 8'h22, 8'h33, 8'h44, 8'h55};
        sense = 10'h0A5;
        repeat (3800) @(negedge clk);
        rd(CMD_INPUT_VOLTAGE, 8'h11);
        rd(CMD_INPUT_CURRENT, 8'h22);
        rd(CMD_OUTPUT_VOLTAGE, 8'hA5);
        rd(CMD_OUTPUT_CURRENT, 8'h33);
        rd(CMD_DIE_TEMPERATURE, 8'h44);
        rd(CMD_INPUT_POWER, 8'h55);
        wr(CMD_INPUT_CURRENT, 1'b1, 8'hFF, 1'b0);
        rd(CMD_INPUT_CURRENT, 8'h22);
        coarse = 1'b1;
        repeat (3800) @(negedge clk);
        rd(CMD_OUTPUT_VOLTAGE, 8'h52);
        $display("t_read done");
    endtask
    task automatic t_flags;
        uv = 1'b1;
        evt = 1'b1;
        ot = 1'b1;
        repeat (5) @(negedge clk);
        rd(CMD_VENDOR_FAULT_STATUS, 8'h07);
        {uv, evt, ot} = 3'b000;
        repeat (5) @(negedge clk);
        rd(CMD_VENDOR_FAULT_STATUS, 8'h05);
        wr(CMD_VENDOR_FAULT_STATUS, 1'b1, 8'h01, 1'b1);
        rd(CMD_VENDOR_FAULT_STATUS, 8'h04);
        wr(CMD_GLOBAL_FAULT_CLEAR, 1'b0, 8'h00, 1'b1);
        rd(CMD_VENDOR_FAULT_STATUS, 8'h00);
        uv = 1'b1;
        repeat (5) @(negedge clk);
        wr(CMD_GLOBAL_FAULT_CLEAR, 1'b0, 8'h00, 1'b1);
        rd(CMD_VENDOR_FAULT_STATUS, 8'h01);
        $display("t_flags done");
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        #1_000_000;
        miscompares++;
        wrap_up();
    end
    initial begin
        repeat (5) @(negedge clk);
        rst_b = 1'b1;
        t_reset();
        t_read();
        t_flags();
        wrap_up();
    end
endmodule // telemetry_status_readback_bench
